// file: include/router_blockage_pkg.sv
// Purpose: shared constants and carriers for the blockage/timeout control
// Assumes: 100 MHz system clock
// Notes: ports numbered 0..10, port 0 is the configuration port
`default_nettype none
package router_blockage_pkg;
  localparam int NUM_PORTS = 11;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMEOUT_US = 60;
  localparam int TIMEOUT_CYCLES = (TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int TIMER_W = 24;
  localparam int REG_W = 32;
  localparam int CFG_ADDR_W = 9;
  localparam int NUM_CFG_REGS = 263;
  localparam logic [8:0] TABLE_LO = 9'h020;
  localparam logic [8:0] TABLE_HI = 9'h0FF;
  localparam logic [8:0] CTRL_ADDR = 9'h100;
  localparam int TIMEOUT_EN_BIT = 0;
  localparam int START_REQ_BIT = 1;
  localparam int REQ_LO = 1;
  localparam int REQ_HI = 10;
  localparam int DEL_HEAD_BIT = 29;
  localparam int PRIORITY_BIT = 30;
  localparam int INVALID_BIT = 31;
  localparam logic [31:0] TABLE_USED_MASK = 32'hE00007FE;
  localparam logic [31:0] CTRL_USED_MASK = 32'h00000003;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WAIT  = 3'b001,
    ST_XFER  = 3'b011,
    ST_SPILL = 3'b010,
    ST_EEP   = 3'b110
  } path_state_t;

  // per-port view of an output port
  typedef struct packed {
    logic running;
    logic busy;
    logic ready;
  } out_status_t;

  // configuration command into the config port
  typedef struct packed {
    logic valid;
    logic write;
    logic [8:0] addr;
    logic [31:0] data;
  } cfg_cmd_t;
endpackage
`default_nettype wire

// file: sim/out_port_model.sv
// Purpose: far-side output ports as seen by the path control
// Assumes: bench sets running, busy and full masks
// Notes: counts and keeps the last character accepted
`default_nettype none
module out_port_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [10:0] runMask,
  input wire logic [10:0] busyMask,
  input wire logic [10:0] fullMask,
  input wire logic outValid,
  input wire logic [8:0] outChar,
  output router_blockage_pkg::out_status_t [10:0] outStatus,
  output logic [8:0] lastChar,
  output int charCount
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    for (int i = 0; i < 11; i++) begin
      outStatus[i].running = runMask[i];
      outStatus[i].busy = busyMask[i];
      outStatus[i].ready = runMask[i] & ~fullMask[i];
    end
  end
  // error-terminated packets are taken like any other
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lastChar <= 9'h000;
      charCount <= 0;
    end else if (outValid) begin
      lastChar <= outChar;
      charCount <= charCount + 1;
    end
  end
endmodule
`default_nettype wire

// file: sim/router_blockage_chk.sv
// Purpose: port checker for the blockage timeout control
// Assumes: one clock, async active-low reset
// Notes: bound from the bench top
`default_nettype none
module router_blockage_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire router_blockage_pkg::cfg_cmd_t cfgCmd,
  input wire logic [31:0] cfgRdata,
  input wire logic cfgRvalid,
  input wire router_blockage_pkg::out_status_t [10:0] outStatus,
  input wire logic [10:0] outGrant,
  input wire logic outValid,
  input wire logic spillPulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [10:0] runVec;
  always_comb begin
    for (int i = 0; i < 11; i++) runVec[i] = outStatus[i].running;
  end
  sequence s_rdCmd;
    cfgCmd.valid && !cfgCmd.write;
  endsequence
  property p_rdAns;
    s_rdCmd |=> cfgRvalid;
  endproperty
  a_rdAns: assert property (p_rdAns) else $error("read not answered");
  property p_noStray;
    cfgRvalid |-> $past(cfgCmd.valid && !cfgCmd.write);
  endproperty
  a_noStray: assert property (p_noStray) else $error("stray rvalid");
  property p_ctrlZero;
    (s_rdCmd and cfgCmd.addr == router_blockage_pkg::CTRL_ADDR)
      |=> cfgRdata[31:2] == 30'h0;
  endproperty
  a_ctrlZero: assert property (p_ctrlZero) else $error("ctrl unused set");
  property p_tblZero;
    (s_rdCmd and cfgCmd.addr inside {[9'h020:9'h0FF]})
      |=> (cfgRdata & ~router_blockage_pkg::TABLE_USED_MASK) == 32'h0;
  endproperty
  a_tblZero: assert property (p_tblZero) else $error("table unused set");
  property p_spillOne;
    spillPulse |=> !spillPulse;
  endproperty
  a_spillOne: assert property (p_spillOne) else $error("spill too long");
  property p_oneGrant;
    $onehot0(outGrant);
  endproperty
  a_oneGrant: assert property (p_oneGrant) else $error("grant not one-hot");
  property p_grantRun;
    $rose(|outGrant) |-> |(outGrant & $past(runVec));
  endproperty
  a_grantRun: assert property (p_grantRun) else $error("grant to down port");
  property p_outGranted;
    outValid |-> |$past(outGrant);
  endproperty
  a_outGranted: assert property (p_outGranted) else $error("output ungranted");
endmodule
`default_nettype wire

// file: sim/test_router_blockage_timeout_control.sv
// Purpose: directed bench for the blockage timeout control
// Assumes: timeout mode after reset
// Notes: timeouts run at full length
`default_nettype none
module test_router_blockage_timeout_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, resetn = 0, inValid = 0, inIsLogical = 0, outValid, spillPulse;
  logic cfgRvalid, inReady;
  router_blockage_pkg::cfg_cmd_t cfgCmd = '0;
  router_blockage_pkg::out_status_t [10:0] outStatus;
  logic [31:0] cfgRdata;
  logic [8:0] inChar = 9'h000, outChar, lastChar;
  logic [7:0] inAddr = 8'h00;
  logic [10:0] outGrant, startRequest, lastGrant, runMask = '1;
  logic [10:0] busyMask = '0, fullMask = '0;
  int failures = 0, checkCount = 0, cyc = 0, charCount, n, c0;
  router_blockage_timeout_control u_router_blockage_timeout_control (
    .clk(clk), .resetn(resetn), .cfgCmd(cfgCmd), .cfgRdata(cfgRdata),
    .cfgRvalid(cfgRvalid), .inValid(inValid), .inChar(inChar),
    .inReady(inReady), .inAddr(inAddr), .inIsLogical(inIsLogical),
    .outStatus(outStatus), .outGrant(outGrant),
    .startRequest(startRequest), .outValid(outValid), .outChar(outChar),
    .spillPulse(spillPulse));
  out_port_model u_out_port_model (.clk(clk), .resetn(resetn),
    .runMask(runMask), .busyMask(busyMask), .fullMask(fullMask),
    .outValid(outValid), .outChar(outChar), .outStatus(outStatus),
    .lastChar(lastChar), .charCount(charCount));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (outGrant != 11'h000) lastGrant <= outGrant;
    if (cyc > 30000) begin
      failures++;
      close_out();
    end
  end
  task automatic close_out();
    if (failures == 0 && checkCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    checkCount++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic cfgWr(input logic [8:0] a, input logic [31:0] d);
    cfgCmd = '{1'b1, 1'b1, a, d};
    tick(1);
    cfgCmd.valid = 1'b0;
    tick(1);
  endtask
  task automatic cfgRd(input logic [8:0] a, input logic [31:0] exp);
    cfgCmd = '{1'b1, 1'b0, a, 32'h0};
    tick(1);
    cfgCmd.valid = 1'b0;
    check("rvalid", cfgRvalid, 32'h1);
    check("rdata", cfgRdata, exp);
    tick(1);
  endtask
  task automatic sendChar(input logic [8:0] ch);
    inChar = ch;
    inValid = 1'b1;
    for (int k = 0; k < 7000 && !inReady; k++) tick(1);
    tick(1);
  endtask
  task automatic waitSpill();
    for (n = 0; n < 7000 && !spillPulse; n++) tick(1);
  endtask
  task automatic t_regs();
    cfgRd(router_blockage_pkg::CTRL_ADDR, router_blockage_pkg::CTRL_RESET);
    cfgWr(9'h020, 32'h0);
    cfgRd(9'h020, 32'h80000000);
    cfgWr(9'h021, 32'hFFFFFFFF);
    cfgRd(9'h021, router_blockage_pkg::TABLE_USED_MASK);
    cfgRd(9'h1F0, 32'h0);
    cfgWr(9'h022, 32'h00000010);
  endtask
  task automatic t_fwd();
    inIsLogical = 1'b1;
    inAddr = 8'h22;
    sendChar(9'h022);
    sendChar(9'h0A5);
    sendChar(9'h100);
    inValid = 1'b0;
    tick(4);
    check("grant", lastGrant, 32'h010);
    check("last", lastChar, 32'h100);
    check("count", charCount, 32'd3);
  endtask
  task automatic t_stall();
    inIsLogical = 1'b0;
    inAddr = 8'h03;
    sendChar(9'h003);
    sendChar(9'h011);
    inValid = 1'b0;
    fullMask[3] = 1'b1;
    tick(router_blockage_pkg::TIMEOUT_CYCLES + 20);
    check("held", lastChar, 32'h011);
    fullMask[3] = 1'b0;
    waitSpill();
    tick(2);
    check("eep", lastChar, 32'h101);
    c0 = charCount;
    sendChar(9'h022);
    sendChar(9'h100);
    inValid = 1'b0;
    tick(3);
    check("spilt", charCount, c0);
  endtask
  task automatic t_down();
    runMask = '0;
    cfgWr(router_blockage_pkg::CTRL_ADDR, 32'h00000003);
    cfgRd(router_blockage_pkg::CTRL_ADDR, 32'h00000003);
    inAddr = 8'h05;
    inChar = 9'h005;
    inValid = 1'b1;
    c0 = charCount;
    tick(2);
    check("startReq", startRequest, 32'h020);
    waitSpill();
    check("late", n >= router_blockage_pkg::TIMEOUT_CYCLES - 10, 1);
    check("inTime", n < 6990, 1);
    sendChar(9'h005);
    sendChar(9'h100);
    inValid = 1'b0;
    tick(3);
    check("quiet", charCount, c0);
  endtask
  initial begin
    tick(5);
    resetn = 1'b1;
    tick(1);
    t_regs();
    t_fwd();
    t_stall();
    t_down();
    close_out();
  end
endmodule
bind router_blockage_timeout_control router_blockage_chk u_router_blockage_chk (
  .clk(clk), .resetn(resetn), .cfgCmd(cfgCmd), .cfgRdata(cfgRdata),
  .cfgRvalid(cfgRvalid), .outStatus(outStatus), .outGrant(outGrant),
  .outValid(outValid), .spillPulse(spillPulse));
`default_nettype wire

// file: src/inactivity_timer.sv
// Purpose: per-port inactivity watchdog
// Assumes: activity pulses on same clock
// Notes: expired is a one-cycle pulse
`default_nettype none
module inactivity_timer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic restart,
  input wire logic stop,
  output logic expired
);
  localparam logic [router_blockage_pkg::TIMER_W-1:0] LIMIT =
    router_blockage_pkg::TIMER_W'(router_blockage_pkg::TIMEOUT_CYCLES - 1);
  logic [router_blockage_pkg::TIMER_W-1:0] count_reg;
  logic running_reg;
  wire atLimit = running_reg && (count_reg == LIMIT);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
      running_reg <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= enable && atLimit;
      if (restart) begin
        count_reg <= '0;
        running_reg <= 1'b1;
      end else if (stop || !enable || atLimit) begin
        count_reg <= '0;
        running_reg <= 1'b0;
      end else if (running_reg) begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: src/router_blockage_timeout_control.sv
// Purpose: input-port path control with blockage timeout and spill
// Assumes: one input port per instance, outputs shared by arbiter outside
// Notes: one timer per instance; replicate per input port
// Contract
// - timeout-enable bit selects timeout or wait-forever
// - timer restarts per character, stops after end
// - hold error end marker until output ready
// - wait-forever keeps stalled-source path allocated
// - timeout spills input and ends output errored
// - each packet to blocked port spills again
// - wait-forever waits, except unstarted link times out
// - group with running member waits forever
// - single unstarted destination: wait timeout, spill
// - start-on-demand forwards once link starts
// - running idle destination forwards at once
// - running busy destination waits without timeout
// - all group ports down: wait, then spill
// - group member running idle forwards at once
// - one busy, others down: wait forever
// - spilled packet sends destination no notice
// - registers 32 bits, unused bits read zero
// - writes ignore unused bit positions
// - 263 registers via configuration commands; code decodes 225 (table 0x020-0x0FF, ctrl 0x100)
// - table maps logical 32-255 to ports
`default_nettype none
module router_blockage_timeout_control (
  input wire logic clk,
  input wire logic resetn,
  input wire router_blockage_pkg::cfg_cmd_t cfgCmd,
  output logic [31:0] cfgRdata,
  output logic cfgRvalid,
  input wire logic inValid,
  input wire logic [8:0] inChar,
  output logic inReady,
  input wire logic [7:0] inAddr,
  input wire logic inIsLogical,
  input wire router_blockage_pkg::out_status_t [10:0] outStatus,
  output logic [10:0] outGrant,
  output logic [10:0] startRequest,
  output logic outValid,
  output logic [8:0] outChar,
  output logic spillPulse
);
  // inChar[8] marks a control char; data[0]=1 means EEP, 0 means EOP
  localparam logic [8:0] EOP_CHAR = 9'h100;
  localparam logic [8:0] EEP_CHAR = 9'h101;

  logic [31:0] routeTable [32:255];
  logic [31:0] ctrl_reg;
  router_blockage_pkg::path_state_t state_reg, state_next;
  logic [10:0] grant_reg, grant_next;
  logic [10:0] mask_reg;
  logic timerExpired;

  function automatic logic [31:0] rd_mask(input logic [31:0] v,
                                          input logic [31:0] m);
    rd_mask = v & m;
  endfunction

  // configuration port
  wire inTable = cfgCmd.addr >= router_blockage_pkg::TABLE_LO &&
    cfgCmd.addr <= router_blockage_pkg::TABLE_HI;
  wire isCtrl = cfgCmd.addr == router_blockage_pkg::CTRL_ADDR;
  wire [31:0] wrTable = rd_mask(cfgCmd.data,
    router_blockage_pkg::TABLE_USED_MASK);
  wire reqEmpty = wrTable[router_blockage_pkg::REQ_HI:
    router_blockage_pkg::REQ_LO] == 10'h000;
  wire [31:0] tableStore = reqEmpty ? 32'h80000000 : wrTable;
  wire [31:0] tableRead = routeTable[cfgCmd.addr[7:0]];
  wire [31:0] readData = inTable ? rd_mask(tableRead,
    router_blockage_pkg::TABLE_USED_MASK) :
    isCtrl ? ctrl_reg : 32'h00000000;

  always_ff @(posedge clk) begin
    if (cfgCmd.valid && cfgCmd.write && inTable) begin
      routeTable[cfgCmd.addr[7:0]] <= tableStore;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= router_blockage_pkg::CTRL_RESET;
      cfgRdata <= 32'h00000000;
      cfgRvalid <= 1'b0;
    end else begin
      cfgRvalid <= cfgCmd.valid && !cfgCmd.write;
      if (cfgCmd.valid && !cfgCmd.write) begin
        cfgRdata <= readData;
      end
      if (cfgCmd.valid && cfgCmd.write && isCtrl) begin
        ctrl_reg <= rd_mask(cfgCmd.data,
          router_blockage_pkg::CTRL_USED_MASK);
      end
    end
  end

  wire timeoutMode = ctrl_reg[router_blockage_pkg::TIMEOUT_EN_BIT];
  wire startOnReq = ctrl_reg[router_blockage_pkg::START_REQ_BIT];

  // destination set for the waiting packet
  wire [31:0] entry = routeTable[inAddr];
  wire [10:0] reqPorts = inIsLogical ?
    {entry[router_blockage_pkg::REQ_HI:router_blockage_pkg::REQ_LO], 1'b0} :
    (inAddr < 8'd11 ? 11'(11'h001 << inAddr[3:0]) : 11'h000);
  wire badAddr = inIsLogical ? entry[router_blockage_pkg::INVALID_BIT] :
    reqPorts == 11'h000;

  logic [10:0] running, busy, ready;
  always_comb begin
    for (int i = 0; i < router_blockage_pkg::NUM_PORTS; i++) begin
      running[i] = outStatus[i].running;
      busy[i] = outStatus[i].busy;
      ready[i] = outStatus[i].ready;
    end
  end

  wire [10:0] freePorts = mask_reg & running & ~busy;
  wire [10:0] anyRun = mask_reg & running;
  // lowest free port wins
  wire [10:0] pick = freePorts & (~freePorts + 11'h001);
  // any running member means no limit on the wait
  wire waitUnbounded = anyRun != 11'h000;
  wire isHead = state_reg == router_blockage_pkg::ST_IDLE;
  wire outReady = (grant_reg & ready) != 11'h000;
  wire inIsEnd = inChar[8];

  // timer activity
  wire moving = state_reg == router_blockage_pkg::ST_XFER && inValid &&
    outReady;
  wire waiting = state_reg == router_blockage_pkg::ST_WAIT;
  wire timerRestart = (moving && !inIsEnd) ||
    (isHead && inValid && !badAddr);
  wire timerStop = (moving && inIsEnd) ||
    (waiting && waitUnbounded && timeoutMode) ||
    (waiting && waitUnbounded && !timeoutMode) ||
    state_reg == router_blockage_pkg::ST_SPILL ||
    state_reg == router_blockage_pkg::ST_EEP;
  // wait-forever still times out for an unstarted destination
  wire timerEnable = timeoutMode || (waiting && !waitUnbounded);

  inactivity_timer watchdog (
    .clk(clk),
    .resetn(resetn),
    .enable(timerEnable),
    .restart(timerRestart || (waiting && waitUnbounded)),
    .stop(timerStop),
    .expired(timerExpired)
  );

  always_comb begin
    state_next = state_reg;
    grant_next = grant_reg;
    case (state_reg)
      router_blockage_pkg::ST_IDLE: begin
        if (inValid) begin
          state_next = badAddr ? router_blockage_pkg::ST_SPILL :
            router_blockage_pkg::ST_WAIT;
        end
      end
      router_blockage_pkg::ST_WAIT: begin
        if (pick != 11'h000) begin
          grant_next = pick;
          state_next = router_blockage_pkg::ST_XFER;
        end else if (timerExpired && !waitUnbounded) begin
          state_next = router_blockage_pkg::ST_SPILL;
        end
      end
      router_blockage_pkg::ST_XFER: begin
        if (moving && inIsEnd) begin
          grant_next = 11'h000;
          state_next = router_blockage_pkg::ST_IDLE;
        end else if (timerExpired && timeoutMode) begin
          state_next = router_blockage_pkg::ST_EEP;
        end
      end
      router_blockage_pkg::ST_SPILL: begin
        if (inValid && inIsEnd) begin
          state_next = router_blockage_pkg::ST_IDLE;
        end
      end
      router_blockage_pkg::ST_EEP: begin
        if (outReady) begin
          grant_next = 11'h000;
          state_next = router_blockage_pkg::ST_SPILL;
        end
      end
      default: begin
        state_next = router_blockage_pkg::ST_IDLE;
        grant_next = 11'h000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= router_blockage_pkg::ST_IDLE;
      grant_reg <= 11'h000;
      mask_reg <= 11'h000;
    end else begin
      state_reg <= state_next;
      grant_reg <= grant_next;
      if (isHead && inValid) begin
        mask_reg <= reqPorts;
      end
    end
  end

  // the head is held, not consumed, until the granted output is ready or the packet spills
  assign inReady = state_reg == router_blockage_pkg::ST_SPILL ||
    (state_reg == router_blockage_pkg::ST_XFER && outReady);
  assign outGrant = grant_reg;
  assign startRequest = (waiting && startOnReq) ?
    (mask_reg & ~running) : 11'h000;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      outValid <= 1'b0;
      outChar <= 9'h000;
      spillPulse <= 1'b0;
    end else begin
      // no notice is sent downstream on a spill, only a local pulse
      spillPulse <= state_reg != router_blockage_pkg::ST_SPILL &&
        state_next == router_blockage_pkg::ST_SPILL;
      if (state_reg == router_blockage_pkg::ST_EEP && outReady) begin
        outValid <= 1'b1;
        outChar <= EEP_CHAR;
      end else if (moving) begin
        outValid <= 1'b1;
        outChar <= inChar;
      end else begin
        outValid <= 1'b0;
        outChar <= EOP_CHAR;
      end
    end
  end
endmodule
`default_nettype wire
